// ---- verilog/trsc_pkg.sv ----
package trsc_pkg;

    // ----------------------------------------
    // Modes and counts
    // ----------------------------------------
    localparam logic [1:0] MM_RESET       = 2'h0;
    localparam logic [1:0] LINK_RETRY_MAX = 2'h3;
    localparam int         COMPAT_BIT     = 0;

    // ----------------------------------------
    // Status frame codes
    // ----------------------------------------
    localparam logic [7:0] TYPE_TX_STATUS = 8'h89;
    localparam logic [7:0] ST_OK          = 8'h00;
    localparam logic [7:0] ST_NOACK       = 8'h01;
    localparam logic [7:0] ST_CCA         = 8'h02;
    localparam logic [7:0] ST_NETACK      = 8'h21;
    localparam logic [7:0] ST_TOOBIG      = 8'h74;

    // ----------------------------------------
    // Payload limits in bytes
    // ----------------------------------------
    localparam logic [7:0] PL_MAX         = 8'h74;
    localparam logic [7:0] PL_COMPAT      = 8'h64;
    localparam logic [7:0] PL_COMPAT_ENC  = 8'h5F;
    localparam logic [7:0] PL_ENC_OVH     = 8'h0B;
    localparam logic [7:0] PL_LONG_ADDR   = 8'h06;
    localparam logic [7:0] PL_HDR         = 8'h02;
    localparam logic [7:0] PL_HDR_ENC     = 8'h04;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] frame_id;
        logic       bcast;
        logic       long_src;
        logic       long_dst;
        logic       encrypt;
        logic [7:0] len;
    } trsc_req_t;

    typedef struct packed {
        logic [7:0] frame_type;
        logic [7:0] frame_id;
        logic [7:0] status;
    } trsc_stat_t;

    typedef struct packed {
        logic [7:0] slot;
        logic       ack_req;
        logic       app_hdr;
        logic       bcast;
    } trsc_air_tx_t;

    typedef struct packed {
        logic [7:0] slot;
        logic       ack_ok;
        logic       cca_fail;
    } trsc_air_res_t;

    typedef struct packed {
        logic       busy;
        logic       wait_air;
        logic [7:0] frame_id;
        logic       bcast;
        logic       hdr;
        logic       ack_req;
        logic [1:0] link_cnt;
        logic [7:0] app_cnt;
        logic [7:0] app_max;
    } trsc_slot_t;

endpackage

// ---- verilog/trsc_buf2.sv ----
`timescale 1ns/1ps
`default_nettype none

module trsc_buf2 #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              wp;
        logic              rp;
        logic [1:0]        cnt;
    } trsc_buf_t;

    trsc_buf_t s, n;
    logic      push, pop;

    if (W < 1) begin : g_chk
        $error("trsc_buf2: W must be positive");
    end

    assign in_ready  = (s.cnt != 2'h2);
    assign out_valid = (s.cnt != 2'h0);
    assign out_data  = s.mem[s.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        n = s;
        if (push) begin
            n.mem[s.wp] = in_data;
            n.wp        = ~s.wp;
        end
        if (pop) begin
            n.rp = ~s.rp;
        end
        n.cnt = 2'(s.cnt + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

endmodule

`default_nettype wire

// ---- verilog/trsc_ctrl.sv ----
// Function
// R1: Modes 0 and 3 add the application header; modes 1 and 2 pass through.
// R2: Duplicate receive detection runs only while the header is in use.
// R3: Modes 0 and 2 set the ack-request flag on unicast frames.
// R4: Unacked unicast is resent at most three more times, stopping on ack.
// R5: Modes 1 and 3 send unicast without ack request and never wait.
// R6: Broadcast frames never carry the ack-request flag.
// R7: Mode setting is 0 after reset.
// R8: Application retries come on top of up to three link retries each.
// R9: Application retries count as zero unless the header is enabled.
// R10: Exactly one status per request with nonzero frame id; none for zero.
// R11: Without app retries: 00 reached, 01 unreached with ack, else 00.
// R12: Channel-clear failure gives 02 after 3 tries and all app retries; the code makes 4 tries (3 link retries) per round.
// R13: With header and app retries, unreached destination gives 21.
// R14: Outside compatibility mode several queued transfers run at once.
// R15: Compatibility bit 0 drops the queue to one transfer at a time.
// R16: Compatibility mode caps payload at 100 bytes, 95 when encrypted.
// R17: Oversized request is refused with status frame 0x89, status 74.
// R18: Retry counters start at zero per request, kept per queue slot.
`timescale 1ns/1ps
`default_nettype none

module trsc_ctrl
    import trsc_pkg::*;
#(
    parameter int NSLOT = 4
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rst,
    // Configuration
    input  wire logic          cfg_wr,
    input  wire logic [1:0]    mac_mode_select,
    input  wire logic [7:0]    app_retry_count,
    input  wire logic [7:0]    compat_options,
    // Host requests
    input  wire logic          req_valid,
    output logic               req_ready,
    input  wire trsc_req_t     req,
    // Status frames
    output logic               stat_valid,
    input  wire logic          stat_ready,
    output trsc_stat_t         stat,
    // Air side
    output logic               air_tx_valid,
    output trsc_air_tx_t       air_tx,
    input  wire logic          air_res_valid,
    output logic               air_res_ready,
    input  wire trsc_air_res_t air_res,
    // Receive duplicate check
    input  wire logic          rx_valid,
    input  wire logic [7:0]    rx_seq,
    output logic               rx_dup
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        trsc_slot_t [NSLOT-1:0] slot;
        logic [1:0]             mm;
        logic [7:0]             rr;
        logic                   compat;
        logic                   air_busy;
        logic                   tx_go;
        trsc_air_tx_t           tx;
        logic [7:0]             last_seq;
        logic                   seq_ok;
        logic                   dup;
    } trsc_state_t;

    trsc_state_t s, n;
    logic        push, buf_ready, res_fire, req_fire, oversize, room;
    trsc_stat_t  pdat;
    logic [1:0]  fin_link;
    logic [7:0]  fin_app, fin_max;
    logic [NSLOT-1:0] busy_vec;

    if (NSLOT < 1 || NSLOT > 256) begin : g_chk
        $error("trsc_ctrl: NSLOT must be 1 to 256");
    end

    // ----------------------------------------
    // Decoders
    // ----------------------------------------
    function automatic logic hdr_on(input logic [1:0] mm);
        return (mm == 2'h0) || (mm == 2'h3);
    endfunction

    function automatic logic ack_on(input logic [1:0] mm);
        return (mm == 2'h0) || (mm == 2'h2);
    endfunction

    function automatic logic [7:0] max_pl(input trsc_req_t r,
                                          input logic hdr,
                                          input logic cmp);
        logic [7:0] m;
        m = PL_MAX;
        if (cmp) begin
            m = r.encrypt ? PL_COMPAT_ENC : PL_COMPAT; // see R16
        end else begin
            // Encryption forces a long source address
            if (r.encrypt) begin
                m = m - PL_ENC_OVH;
            end else if (r.long_src) begin
                m = m - PL_LONG_ADDR;
            end
            if (r.long_dst) begin
                m = m - PL_LONG_ADDR;
            end
            if (hdr) begin
                m = m - (r.encrypt ? PL_HDR_ENC : PL_HDR);
            end
        end
        return m;
    endfunction

    function automatic trsc_stat_t mk_stat(input logic [7:0] id,
                                           input logic [7:0] code);
        trsc_stat_t t;
        t.frame_type = TYPE_TX_STATUS;
        t.frame_id   = id;
        t.status     = code;
        return t;
    endfunction

    // ----------------------------------------
    // Handshakes
    // ----------------------------------------
    always_comb begin
        busy_vec = '0;
        for (int i = 0; i < NSLOT; i++) begin
            busy_vec[i] = s.slot[i].busy;
        end
    end

    // Compatibility mode admits a request only with the queue empty
    assign room = s.compat ? (busy_vec == '0) : (busy_vec != '1); // see R15
    assign air_res_ready = s.air_busy && buf_ready;
    assign res_fire      = air_res_valid && air_res_ready;
    // A finishing transfer owns the status path this cycle
    assign req_ready     = buf_ready && !res_fire && room;
    assign req_fire      = req_valid && req_ready;
    assign oversize      = req.len > max_pl(req, hdr_on(s.mm), s.compat);

    assign air_tx_valid  = s.tx_go;
    assign air_tx        = s.tx;
    assign rx_dup        = s.dup;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        int         idx;
        int         pick;
        int         fr;
        trsc_slot_t sl;
        logic       fin;
        logic       retry;
        logic [7:0] code;
        idx      = int'(air_res.slot);
        pick     = NSLOT;
        fr       = NSLOT;
        sl       = '0;
        fin      = 1'b0;
        retry    = 1'b0;
        code     = ST_OK;
        n        = s;
        n.tx_go  = 1'b0;
        n.dup    = 1'b0;
        push     = 1'b0;
        pdat     = '0;
        fin_link = '0;
        fin_app  = '0;
        fin_max  = '0;

        if (cfg_wr) begin
            n.mm     = mac_mode_select;
            n.rr     = app_retry_count;
            n.compat = compat_options[COMPAT_BIT];
        end

        // Outcome of the transfer on the air
        if (res_fire) begin
            n.air_busy = 1'b0;
            if (idx < NSLOT) begin
                sl = s.slot[idx];
            end
            if (sl.busy && sl.wait_air) begin
                if (air_res.cca_fail) begin
                    if (sl.link_cnt < LINK_RETRY_MAX) begin
                        sl.link_cnt = 2'(sl.link_cnt + 2'h1); // see R12
                        retry = 1'b1;
                    end else if (sl.app_cnt < sl.app_max) begin
                        sl.app_cnt  = sl.app_cnt + 8'h01; // see R12
                        sl.link_cnt = '0;
                        retry = 1'b1;
                    end else begin
                        fin  = 1'b1;
                        code = ST_CCA; // see R12
                    end
                end else if (sl.bcast || air_res.ack_ok
                             || (!sl.ack_req && sl.app_max == 8'h00)) begin
                    fin  = 1'b1;
                    code = ST_OK; // see R11
                end else if (sl.ack_req && sl.link_cnt < LINK_RETRY_MAX) begin
                    sl.link_cnt = 2'(sl.link_cnt + 2'h1); // see R4
                    retry = 1'b1;
                end else if (sl.app_cnt < sl.app_max) begin
                    // Each app retry restarts the link budget
                    sl.app_cnt  = sl.app_cnt + 8'h01; // see R8
                    sl.link_cnt = '0;
                    retry = 1'b1;
                end else begin
                    fin  = 1'b1;
                    code = (sl.app_max == 8'h00) ? ST_NOACK
                                                 : ST_NETACK; // see R11 R13
                end
                fin_link = sl.link_cnt;
                fin_app  = sl.app_cnt;
                fin_max  = sl.app_max;
                if (retry) begin
                    sl.wait_air = 1'b0;
                end
                if (fin) begin
                    sl.busy     = 1'b0;
                    sl.wait_air = 1'b0;
                    push = (sl.frame_id != 8'h00); // see R10
                    pdat = mk_stat(sl.frame_id, code);
                end
                n.slot[idx] = sl;
            end
        end

        // New host request
        if (req_fire) begin
            if (oversize) begin
                push = (req.frame_id != 8'h00); // see R17 R10
                pdat = mk_stat(req.frame_id, ST_TOOBIG);
            end else begin
                for (int i = NSLOT - 1; i >= 0; i--) begin
                    if (!s.slot[i].busy) begin
                        fr = i;
                    end
                end
                if (fr < NSLOT) begin
                    // Fresh counters per request and per slot
                    n.slot[fr].busy     = 1'b1; // see R14 R18
                    n.slot[fr].wait_air = 1'b0;
                    n.slot[fr].frame_id = req.frame_id;
                    n.slot[fr].bcast    = req.bcast;
                    n.slot[fr].hdr      = hdr_on(s.mm); // see R1
                    n.slot[fr].ack_req  = ack_on(s.mm)
                                          && !req.bcast; // see R3 R5 R6
                    n.slot[fr].link_cnt = '0; // see R18
                    n.slot[fr].app_cnt  = '0;
                    n.slot[fr].app_max  = hdr_on(s.mm) ? s.rr
                                                       : 8'h00; // see R9
                end
            end
        end

        // Round of the queue: lowest ready slot goes on air next
        if (!s.air_busy) begin
            for (int i = NSLOT - 1; i >= 0; i--) begin
                if (s.slot[i].busy && !s.slot[i].wait_air) begin
                    pick = i;
                end
            end
            if (pick < NSLOT) begin
                n.slot[pick].wait_air = 1'b1;
                n.air_busy   = 1'b1;
                n.tx_go      = 1'b1;
                n.tx.slot    = 8'(pick);
                n.tx.ack_req = s.slot[pick].ack_req;
                n.tx.app_hdr = s.slot[pick].hdr;
                n.tx.bcast   = s.slot[pick].bcast;
            end
        end

        // Duplicate filter only has sequence numbers with the header
        if (rx_valid) begin
            n.last_seq = rx_seq;
            n.seq_ok   = hdr_on(s.mm);
            n.dup      = hdr_on(s.mm) && s.seq_ok
                         && (rx_seq == s.last_seq); // see R2
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s    <= '0;
            s.mm <= MM_RESET; // see R7
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------
    // Status buffer
    // ----------------------------------------
    trsc_buf2 #(
        .W ($bits(trsc_stat_t))
    ) trsc_buf2_inst (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .in_data   (pdat),
        .out_valid (stat_valid),
        .out_ready (stat_ready),
        .out_data  (stat)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic first_q;
    logic mode_clean_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            first_q      <= 1'b1;
            mode_clean_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
            if (cfg_wr && (busy_vec != '0 || req_fire)) begin
                mode_clean_q <= 1'b0;
            end else if (busy_vec == '0) begin
                mode_clean_q <= 1'b1;
            end
        end
    end

    property p_reset_mode;
        @(posedge clk_sys) disable iff (rst)
        first_q |-> s.mm == MM_RESET;
    endproperty
    a_reset_mode: assert property (p_reset_mode) // see R7
        else $error("mode not zero after reset");

    property p_bcast_noack;
        @(posedge clk_sys) disable iff (rst)
        air_tx_valid && air_tx.bcast |-> !air_tx.ack_req;
    endproperty
    a_bcast_noack: assert property (p_bcast_noack) // see R6
        else $error("broadcast sent with ack request");

    property p_ack_mode;
        @(posedge clk_sys) disable iff (rst)
        air_tx_valid && !air_tx.bcast && mode_clean_q && !$past(cfg_wr)
            |-> air_tx.ack_req == ack_on(s.mm);
    endproperty
    a_ack_mode: assert property (p_ack_mode) // see R3 R5
        else $error("ack request does not follow mode");

    property p_hdr_mode;
        @(posedge clk_sys) disable iff (rst)
        air_tx_valid && mode_clean_q && !$past(cfg_wr)
            |-> air_tx.app_hdr == hdr_on(s.mm);
    endproperty
    a_hdr_mode: assert property (p_hdr_mode) // see R1
        else $error("header use does not follow mode");

    property p_noack_after3;
        @(posedge clk_sys) disable iff (rst)
        push && pdat.status == ST_NOACK
            |-> fin_link == LINK_RETRY_MAX && fin_max == 8'h00;
    endproperty
    a_noack_after3: assert property (p_noack_after3) // see R4 R11
        else $error("no-ack status before three link retries");

    property p_netack;
        @(posedge clk_sys) disable iff (rst)
        push && (pdat.status == ST_NETACK || pdat.status == ST_CCA)
            && fin_max != 8'h00 |-> fin_app == fin_max;
    endproperty
    a_netack: assert property (p_netack) // see R13 R12 R9
        else $error("app retries not used up");

    property p_no_zero_id;
        @(posedge clk_sys) disable iff (rst)
        push |-> pdat.frame_id != 8'h00 ##1 stat_valid;
    endproperty
    a_no_zero_id: assert property (p_no_zero_id) // see R10
        else $error("status for frame id zero or lost");

    property p_toobig;
        @(posedge clk_sys) disable iff (rst)
        req_fire && oversize && req.frame_id != 8'h00
            |-> push && pdat.status == ST_TOOBIG
                && pdat.frame_type == TYPE_TX_STATUS;
    endproperty
    a_toobig: assert property (p_toobig) // see R17
        else $error("oversize request not refused");

    property p_compat_one;
        @(posedge clk_sys) disable iff (rst)
        req_fire && s.compat |-> busy_vec == '0;
    endproperty
    a_compat_one: assert property (p_compat_one) // see R15
        else $error("queue used in compatibility mode");

    property p_dup_hdr;
        @(posedge clk_sys) disable iff (rst)
        rx_dup |-> hdr_on($past(s.mm));
    endproperty
    a_dup_hdr: assert property (p_dup_hdr) // see R2
        else $error("duplicate flagged without header");

    c_netack: cover property (@(posedge clk_sys) disable iff (rst)
        push && pdat.status == ST_NETACK);
    c_cca: cover property (@(posedge clk_sys) disable iff (rst)
        push && pdat.status == ST_CCA);
    c_toobig: cover property (@(posedge clk_sys) disable iff (rst)
        push && pdat.status == ST_TOOBIG);
    c_two_busy: cover property (@(posedge clk_sys) disable iff (rst)
        $countones(busy_vec) >= 2);

endmodule

`default_nettype wire

// ---- verification/trsc_air_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module trsc_air_model
    import trsc_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rst,
    // Scenario controls
    input  wire logic          reach,
    input  wire logic          busy_chan,
    input  wire logic [7:0]    lat,
    // Air side
    input  wire logic          air_tx_valid,
    input  wire trsc_air_tx_t  air_tx,
    output logic               air_res_valid,
    input  wire logic          air_res_ready,
    output trsc_air_res_t      air_res,
    // Observation
    output int                 tx_count,
    output trsc_air_tx_t       last_tx
);
    logic       pend_q;
    logic [7:0] wait_q;

    // ----------------------------------------
    // One frame on air at a time
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_q <= 1'b0;
            wait_q <= 8'h00;
            air_res_valid <= 1'b0;
            air_res <= '0;
            tx_count <= 0;
            last_tx <= '0;
        end else if (air_tx_valid) begin
            tx_count <= tx_count + 1;
            last_tx <= air_tx;
            pend_q <= 1'b1;
            wait_q <= lat;
        end else if (pend_q && !air_res_valid) begin
            if (wait_q == 8'h00) begin
                air_res_valid <= 1'b1;
                // Receiver acks only when reachable and channel clear
                air_res <= '{last_tx.slot, reach & ~busy_chan, busy_chan};
            end else begin
                wait_q <= wait_q - 8'h01;
            end
        end else if (air_res_valid && air_res_ready) begin
            air_res_valid <= 1'b0;
            pend_q <= 1'b0;
            // Released lines must not keep a plausible value
            air_res <= ~air_res;
        end
    end
endmodule

`default_nettype wire

// ---- verification/trsc_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module trsc_ctrl_tb_top import trsc_pkg::*;;
    typedef struct packed {
        logic [1:0] mode; logic [7:0] rr; logic bcast; logic reach;
        logic cca; logic [7:0] lat; logic [7:0] st; logic [7:0] ntx;
        logic ack; logic hdr;
    } trsc_row_t;

    logic clk_sys = 1'b0, rst = 1'b1, cfg_wr = 1'b0, req_valid = 1'b0;
    logic [1:0] mac_mode_select = 2'h0;
    logic [7:0] app_retry_count = 8'h00, compat_options = 8'h00;
    logic [7:0] rx_seq = 8'h00, lat = 8'h00;
    logic stat_ready = 1'b1, rx_valid = 1'b0, reach = 1'b1, busy_chan = 1'b0;
    logic req_ready, stat_valid, air_tx_valid, air_res_valid;
    logic air_res_ready, rx_dup;
    trsc_req_t req = '0;
    trsc_stat_t stat, s;
    trsc_air_tx_t air_tx, last_tx;
    trsc_air_res_t air_res;
    trsc_stat_t got[$];
    int tx_count, base, fails = 0, check_count = 0;
    logic [7:0] pl [8] = '{8'h65,8'h64,8'h60,8'h5F,8'h60,8'h5F,8'h75,8'h74};
    trsc_row_t rows [11] = '{
        '{2'h0,8'h00,1'b0,1'b1,1'b0,8'h00,ST_OK,8'h01,1'b1,1'b1},
        '{2'h0,8'h00,1'b0,1'b0,1'b0,8'h03,ST_NOACK,8'h04,1'b1,1'b1},
        '{2'h1,8'h00,1'b0,1'b0,1'b0,8'h00,ST_OK,8'h01,1'b0,1'b0},
        '{2'h2,8'h05,1'b0,1'b0,1'b0,8'h01,ST_NOACK,8'h04,1'b1,1'b0},
        '{2'h3,8'h02,1'b0,1'b0,1'b0,8'h00,ST_NETACK,8'h03,1'b0,1'b1},
        '{2'h0,8'h02,1'b0,1'b0,1'b0,8'h02,ST_NETACK,8'h0C,1'b1,1'b1},
        '{2'h0,8'h02,1'b0,1'b1,1'b0,8'h00,ST_OK,8'h01,1'b1,1'b1},
        '{2'h0,8'h00,1'b0,1'b0,1'b1,8'h00,ST_CCA,8'h04,1'b1,1'b1},
        '{2'h3,8'h01,1'b0,1'b0,1'b1,8'h00,ST_CCA,8'h08,1'b0,1'b1},
        '{2'h2,8'h00,1'b1,1'b0,1'b0,8'h00,ST_OK,8'h01,1'b0,1'b0},
        '{2'h1,8'h00,1'b0,1'b0,1'b1,8'h00,ST_CCA,8'h04,1'b0,1'b0}};

    trsc_ctrl trsc_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .cfg_wr(cfg_wr),
        .mac_mode_select(mac_mode_select), .app_retry_count(app_retry_count),
        .compat_options(compat_options), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .stat_valid(stat_valid),
        .stat_ready(stat_ready), .stat(stat), .air_tx_valid(air_tx_valid),
        .air_tx(air_tx), .air_res_valid(air_res_valid),
        .air_res_ready(air_res_ready), .air_res(air_res),
        .rx_valid(rx_valid), .rx_seq(rx_seq), .rx_dup(rx_dup));
    trsc_air_model trsc_air_model_inst (.clk_sys(clk_sys), .rst(rst),
        .reach(reach), .busy_chan(busy_chan), .lat(lat),
        .air_tx_valid(air_tx_valid), .air_tx(air_tx),
        .air_res_valid(air_res_valid), .air_res_ready(air_res_ready),
        .air_res(air_res), .tx_count(tx_count), .last_tx(last_tx));

    // ----------------------------------------
    // Clock, status monitor, shared tasks
    // ----------------------------------------
    initial forever #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (stat_valid && stat_ready) got.push_back(stat);

    task automatic report_and_stop();
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic cfg(input logic [1:0] m, input logic [7:0] r, c);
        @(posedge clk_sys);
        cfg_wr <= 1'b1;
        mac_mode_select <= m;
        app_retry_count <= r;
        compat_options <= c;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
    endtask
    task automatic send(input logic [7:0] id, input logic bc, en,
                        input logic [7:0] ln);
        int n;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{id, bc, 1'b0, en, en, ln};
        for (n = 0; n < 500; n++) begin
            @(posedge clk_sys);
            if (req_ready === 1'b1) break;
        end
        req_valid <= 1'b0;
        if (n == 500) begin fails++; report_and_stop(); end
    endtask
    task automatic wait_stat(input logic [7:0] st);
        int n;
        for (n = 0; n < 3000 && got.size() == 0; n++) @(posedge clk_sys);
        if (n == 3000) begin fails++; report_and_stop(); end
        s = got.pop_front();
        check(s.frame_type, TYPE_TX_STATUS);
        check(s.status, st);
    endtask
    task automatic rx(input logic [7:0] sq, input logic exp, chk);
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_seq <= sq;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        @(posedge clk_sys);
        if (chk) check(rx_dup, exp);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check({stat_valid, air_tx_valid, air_res_ready, rx_dup}, 0);
        send(8'h40, 1'b0, 1'b0, 8'h10);
        wait_stat(ST_OK);
        check({last_tx.ack_req, last_tx.app_hdr}, 2'h3);
        foreach (rows[i]) begin
            cfg(rows[i].mode, rows[i].rr, 8'h00);
            reach <= rows[i].reach;
            busy_chan <= rows[i].cca;
            lat <= rows[i].lat;
            base = tx_count;
            send(8'(i + 1), rows[i].bcast, 1'b0, 8'h10);
            wait_stat(rows[i].st);
            check(s.frame_id, i + 1);
            check(tx_count - base, rows[i].ntx);
            check(last_tx.ack_req, rows[i].ack);
            check(last_tx.app_hdr, rows[i].hdr);
        end
        reach <= 1'b1;
        busy_chan <= 1'b0;
        // Payload edges: compat plain/enc, open enc long dst, open plain
        for (int k = 0; k < 8; k++) begin
            cfg(k < 6 ? 2'h0 : 2'h1, 8'h00, k < 4 ? 8'h01 : 8'h00);
            send(8'h30, 1'b0, k inside {[2:5]}, pl[k]);
            wait_stat(k[0] ? ST_OK : ST_TOOBIG);
        end
        base = tx_count;
        send(8'h00, 1'b0, 1'b0, 8'h10);
        repeat (40) @(posedge clk_sys);
        check(got.size(), 0);
        check(tx_count - base, 1);
        lat <= 8'h28;
        cfg(2'h1, 8'h00, 8'h00);
        send(8'h51, 1'b0, 1'b0, 8'h10);
        repeat (3) @(posedge clk_sys);
        check(req_ready, 1'b1);
        send(8'h52, 1'b0, 1'b0, 8'h10);
        wait_stat(ST_OK);
        wait_stat(ST_OK);
        cfg(2'h1, 8'h00, 8'h01);
        send(8'h53, 1'b0, 1'b0, 8'h10);
        repeat (3) @(posedge clk_sys);
        check(req_ready, 1'b0);
        wait_stat(ST_OK);
        // Host stalls; two refusals fill the status buffer
        stat_ready <= 1'b0;
        send(8'h61, 1'b0, 1'b0, 8'hFF);
        send(8'h62, 1'b0, 1'b0, 8'hFF);
        repeat (2) @(posedge clk_sys);
        check({stat_valid, req_ready}, 2'h2);
        stat_ready <= 1'b1;
        wait_stat(ST_TOOBIG);
        check(s.frame_id, 8'h61);
        wait_stat(ST_TOOBIG);
        check(s.frame_id, 8'h62);
        @(posedge clk_sys);
        check(stat_valid, 1'b0);
        cfg(2'h0, 8'h00, 8'h00);
        rx(8'h05, 1'b0, 1'b0);
        rx(8'h05, 1'b1, 1'b1);
        rx(8'h06, 1'b0, 1'b1);
        cfg(2'h1, 8'h00, 8'h00);
        rx(8'h07, 1'b0, 1'b0);
        rx(8'h07, 1'b0, 1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        send(8'h41, 1'b0, 1'b0, 8'h10);
        wait_stat(ST_OK);
        check({last_tx.ack_req, last_tx.app_hdr}, 2'h3);
        report_and_stop();
    end
endmodule

`default_nettype wire
